// ==== lane_error_counter_pkg.sv ====
// Package for the lane error counter control block: register map,
// field layout, reset values and bus carrier types.
// Assumes a 32-bit APB master on pclk; one register per aligned word.
package lane_error_counter_pkg;

    // Register indices; the byte address is four times the index
    localparam logic [11:0] IDX_LANE6_SAT   = 12'h048E;
    localparam logic [11:0] IDX_LANE7_SAT   = 12'h048F;
    localparam logic [11:0] IDX_LANE0_STAT  = 12'h0490;
    localparam logic [11:0] IDX_IRQ_STATUS  = 12'h04A0;
    localparam logic [11:0] IDX_IRQ_MASK    = 12'h04A1;

    // Byte address shift from index
    localparam int ADDR_SHIFT = 2;

    // Counter field positions inside each three-bit lane field
    localparam int BIT_UNEXP_CTRL = 2;
    localparam int BIT_NOT_IN_TBL = 1;
    localparam int BIT_BAD_DISP   = 0;
    localparam int CNT_PER_LANE   = 3;

    // Lane status register layout
    localparam int STAT_ENA_BIT   = 3;

    // Lanes served by the configuration and status registers
    localparam int LANE_STAT      = 0;
    localparam int LANE_SAT_A     = 6;
    localparam int LANE_SAT_B     = 7;

    // Reset values
    localparam logic [2:0]  SAT_RESET  = 3'h7;
    localparam logic [8:0]  IRQ_RESET  = 9'h000;
    localparam logic [31:0] ZERO_WORD  = 32'h0000_0000;

    // Interrupt status layout: lane 0, lane 6, lane 7 fields
    localparam int IRQ_W      = 9;
    localparam int IRQ_L0_LSB = 0;
    localparam int IRQ_L6_LSB = 3;
    localparam int IRQ_L7_LSB = 6;

    // APB request from the master
    typedef struct packed {
        logic        psel;
        logic        penable;
        logic        pwrite;
        logic [31:0] paddr;
        logic [31:0] pwdata;
    } apb_req_s;

endpackage

// ==== lane_error_counter_control.sv ====
// Per-lane error counters, with saturate or wrap control for lanes 6 and 7
// and a terminal-count status word for lane 0, reached over APB.
// Assumes error events and lane enables are synchronous to pclk.
`timescale 1ns/1ps

// One error counter with saturate or wrap behaviour
// inc and clr are one-cycle pulses; sat_en is a level read every cycle
// hit pulses in the cycle whose edge brings the count to terminal
module lane_err_counter #(
    parameter int CNT_W = 8
) (
    input  wire logic             pclk,
    input  wire logic             presetn,
    input  wire logic             inc,
    input  wire logic             clr,
    input  wire logic             sat_en,
    output logic [CNT_W-1:0]      count,
    output logic                  reached,
    output logic                  hit
);

    // Terminal count is all ones at any width
    localparam logic [CNT_W-1:0] TERM = {CNT_W{1'b1}};
    localparam logic [CNT_W-1:0] ONE  = {{(CNT_W-1){1'b0}}, 1'b1};

    // Count and flag state with their next values
    logic [CNT_W-1:0] count_reg;
    logic [CNT_W-1:0] count_next;
    logic             reached_reg;
    logic             reached_next;
    wire              at_term;
    wire              pre_term;
    wire              hold;
    wire              step;
    wire [CNT_W-1:0]  step_value;
    wire [CNT_W-1:0]  clear_value;

    // Terminal count and the value just below it
    // Both compare the stored count, so an event in flight is not seen yet
    assign at_term  = (count_reg == TERM);
    assign pre_term = (count_reg == TERM - ONE);

    // Hold at terminal count when saturating
    // The saturate bit is read every cycle, so a change takes effect at once
    assign hold    = at_term & sat_en;

    // An event moves the count only when neither clear nor hold applies
    assign step    = inc & ~clr & ~hold;

    // Plain increment; the carry out of the top bit is dropped on purpose
    // so that a wrapping counter goes from terminal count back to zero
    assign step_value = count_reg + ONE;

    // A clear that meets an event in the same cycle keeps that event
    assign clear_value = inc ? ONE : '0;

    // Next count: clear, hold, or increment with natural wrap
    assign count_next = clr  ? clear_value :
                        hold ? count_reg :
                        step ? step_value :
                        count_reg;

    // Pulse when this increment lands on terminal count
    // A held or cleared counter never pulses, so each arrival is seen once
    assign hit = step & pre_term;

    // Flag stays set once terminal count was reached
    // It survives a later wrap; only the user clear takes it down
    // A clear wins here because the count restarts from zero or one
    // No terminal event can meet a clear, as the count then restarts
    assign reached_next = clr ? 1'b0 : (reached_reg | hit);

    // Count register; reset loads zero
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            count_reg <= '0;
        end else begin
            count_reg <= count_next;
        end
    end

    // Reached flag register; reads zero after reset
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            reached_reg <= 1'b0;
        end else begin
            reached_reg <= reached_next;
        end
    end

    // Outputs straight from the flip-flops
    assign count   = count_reg;
    assign reached = reached_reg;

endmodule // lane_err_counter

// Top level: counters for all lanes plus the register file
// Only lanes 6 and 7 have saturate fields here and only lane 0 a status
// word; the other lanes count with saturation on
// The interrupt words are local to this block
module lane_error_counter_control #(
    parameter int NUM_LANES = 8,
    parameter int CNT_W     = 8
) (
    input  wire logic                                 pclk,
    input  wire logic                                 presetn,
    input  wire lane_error_counter_pkg::apb_req_s     apb_req,
    output logic [31:0]                               prdata,
    output logic                                      pready,
    output logic                                      pslverr,
    input  wire logic [NUM_LANES-1:0][2:0]            lane_err_event,
    input  wire logic [NUM_LANES-1:0][2:0]            lane_cnt_clear,
    input  wire logic [NUM_LANES-1:0]                 lane_enable,
    output logic [NUM_LANES-1:0][2:0][CNT_W-1:0]      err_count,
    output logic [NUM_LANES-1:0][2:0]                 terminal_reached,
    output logic                                      irq
);

    // Address shift and interrupt field width
    localparam int SH = lane_error_counter_pkg::ADDR_SHIFT;
    localparam int IW = lane_error_counter_pkg::IRQ_W;

    // Saturate field registers
    logic [2:0]    lane6_saturate_enable_reg;
    logic [2:0]    lane6_saturate_enable_next;
    logic [2:0]    lane7_saturate_enable_reg;
    logic [2:0]    lane7_saturate_enable_next;

    // Interrupt registers
    logic [IW-1:0] irq_status_reg;
    logic [IW-1:0] irq_status_next;
    logic [IW-1:0] irq_mask_reg;
    logic [IW-1:0] irq_mask_next;

    // Read data and lane 0 enable
    logic [31:0]   prdata_reg;
    logic [31:0]   prdata_next;
    logic          lane0_enabled_flag_reg;

    // Per-lane saturate settings and counter events
    logic [NUM_LANES-1:0][2:0] sat_en;
    logic [NUM_LANES-1:0][2:0] hit;

    // Bus phase decode
    // Every transfer ends in its first access cycle, so the access phase
    // itself is the completion strobe and no wait state is counted
    wire setup_ph  = apb_req.psel & ~apb_req.penable;
    wire access_ph = apb_req.psel &  apb_req.penable;

    // Direction of a completing transfer
    wire wr_done   = access_ph & apb_req.pwrite;
    wire rd_done   = access_ph & ~apb_req.pwrite;

    // Address decode on aligned words
    // A set byte-offset bit or any bit above the index misses every register
    wire [11:0] idx      = apb_req.paddr[SH +: 12];
    wire        byte_off = (apb_req.paddr[SH-1:0] != '0);
    wire        high_set = (apb_req.paddr[31:SH+12] != '0);
    wire        aligned  = ~byte_off & ~high_set;

    // One select per register word
    wire sel_sat6  = aligned & (idx == lane_error_counter_pkg::IDX_LANE6_SAT);
    wire sel_sat7  = aligned & (idx == lane_error_counter_pkg::IDX_LANE7_SAT);
    wire sel_stat0 = aligned & (idx == lane_error_counter_pkg::IDX_LANE0_STAT);
    wire sel_irqst = aligned & (idx == lane_error_counter_pkg::IDX_IRQ_STATUS);
    wire sel_irqmk = aligned & (idx == lane_error_counter_pkg::IDX_IRQ_MASK);

    // Any register hit; a miss answers with the bus error
    wire mapped    = sel_sat6 | sel_sat7 | sel_stat0 | sel_irqst | sel_irqmk;

    // Per-register write and read strobes
    // A missed address raises none of them, so such a write is lost
    wire wr_sat6   = wr_done & sel_sat6;
    wire wr_sat7   = wr_done & sel_sat7;
    wire wr_irqmk  = wr_done & sel_irqmk;
    wire rd_irqst  = rd_done & sel_irqst;

    // Saturate field per lane; lanes outside this block keep the reset setting
    // Each lane reads only its own field, so lanes never share a setting
    always_comb begin
        for (int l = 0; l < NUM_LANES; l++) begin
            sat_en[l] = lane_error_counter_pkg::SAT_RESET;
        end
        sat_en[lane_error_counter_pkg::LANE_SAT_A] = lane6_saturate_enable_reg;
        sat_en[lane_error_counter_pkg::LANE_SAT_B] = lane7_saturate_enable_reg;
    end

    // Three counters per lane, indexed by the field bit position
    // Field bits 2, 1 and 0 drive the unexpected control character,
    // not-in-table and disparity counters
    // The clear port is the user reset of a counter
    for (genvar l = 0; l < NUM_LANES; l++) begin : g_lane
        for (genvar c = 0; c < lane_error_counter_pkg::CNT_PER_LANE; c++) begin : g_cnt
            lane_err_counter #(
                .CNT_W   (CNT_W)
            ) u_cnt (
                .pclk    (pclk),
                .presetn (presetn),
                .inc     (lane_err_event[l][c]),
                .clr     (lane_cnt_clear[l][c]),
                .sat_en  (sat_en[l][c]),
                .count   (err_count[l][c]),
                .reached (terminal_reached[l][c]),
                .hit     (hit[l][c])
            );
        end
    end

    // Saturate field writes; upper bits are dropped
    // The block does not police when software writes these fields; a change
    // in normal operation takes effect on the next event of that counter
    // Software keeps them still while the deframer runs
    assign lane6_saturate_enable_next = wr_sat6 ?
                                        apb_req.pwdata[2:0] :
                                        lane6_saturate_enable_reg;
    assign lane7_saturate_enable_next = wr_sat7 ?
                                        apb_req.pwdata[2:0] :
                                        lane7_saturate_enable_reg;

    // Lane 0 reached flags, shared by the status word
    wire [2:0]    lane0_terminal_reached = terminal_reached[lane_error_counter_pkg::LANE_STAT];

    // Terminal-count events of lanes 0, 6 and 7
    // Lane 0 fills bits 2:0, lane 6 bits 5:3 and lane 7 bits 8:6
    wire [2:0]    irq_ev_lane0 = hit[lane_error_counter_pkg::LANE_STAT];
    wire [2:0]    irq_ev_lane6 = hit[lane_error_counter_pkg::LANE_SAT_A];
    wire [2:0]    irq_ev_lane7 = hit[lane_error_counter_pkg::LANE_SAT_B];
    wire [IW-1:0] irq_events   = {irq_ev_lane7, irq_ev_lane6, irq_ev_lane0};

    // Read clears the bits that were returned; a new event wins
    // Clearing only the returned bits means an event that lands between
    // the setup and access cycles is kept for the next read
    wire [IW-1:0] irq_rd_clr = rd_irqst ? prdata_reg[IW-1:0] : '0;
    assign irq_status_next = (irq_status_reg & ~irq_rd_clr) | irq_events;

    // Mask register of the same layout as the status register
    assign irq_mask_next   = wr_irqmk ? apb_req.pwdata[IW-1:0] :
                             irq_mask_reg;

    // Lane 0 status word: enabled flag over the reached flags
    // The flags are read-only; a write to this word changes nothing
    wire [31:0] stat0_word = {28'h000_0000,
                              lane0_enabled_flag_reg,
                              lane0_terminal_reached};

    // Saturate words; bits above the field read zero
    wire [31:0] sat6_word  = {29'h0000_0000, lane6_saturate_enable_reg};
    wire [31:0] sat7_word  = {29'h0000_0000, lane7_saturate_enable_reg};

    // Interrupt words; bits above the nine field bits read zero
    wire [31:0] irqst_word = {23'h00_0000, irq_status_reg};
    wire [31:0] irqmk_word = {23'h00_0000, irq_mask_reg};

    // Selected word; an unmapped address reads zero
    wire [31:0] read_word  = sel_sat6  ? sat6_word :
                             sel_sat7  ? sat7_word :
                             sel_stat0 ? stat0_word :
                             sel_irqst ? irqst_word :
                             sel_irqmk ? irqmk_word :
                             lane_error_counter_pkg::ZERO_WORD;

    // Read data is captured in the setup cycle and held through the access,
    // so the value that the read-clear removes is the value returned
    assign prdata_next = setup_ph ? read_word : prdata_reg;

    // Saturate field of lane 6; all ones after reset
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            lane6_saturate_enable_reg <= lane_error_counter_pkg::SAT_RESET;
        end else begin
            lane6_saturate_enable_reg <= lane6_saturate_enable_next;
        end
    end

    // Saturate field of lane 7; all ones after reset
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            lane7_saturate_enable_reg <= lane_error_counter_pkg::SAT_RESET;
        end else begin
            lane7_saturate_enable_reg <= lane7_saturate_enable_next;
        end
    end

    // Interrupt status: sticky bits set by terminal-count events
    // and cleared by a read of the status word
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_status_reg <= lane_error_counter_pkg::IRQ_RESET;
        end else begin
            irq_status_reg <= irq_status_next;
        end
    end

    // Interrupt mask; all bits masked after reset
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_mask_reg <= lane_error_counter_pkg::IRQ_RESET;
        end else begin
            irq_mask_reg <= irq_mask_next;
        end
    end

    // Read data register; holds the word captured in the setup cycle
    // until the next setup cycle loads another
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_reg <= lane_error_counter_pkg::ZERO_WORD;
        end else begin
            prdata_reg <= prdata_next;
        end
    end

    // Lane 0 enable as reported in the status word
    // One flip-flop stage; the status shows the enable one cycle late
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            lane0_enabled_flag_reg <= 1'b0;
        end else begin
            lane0_enabled_flag_reg <= lane_enable[lane_error_counter_pkg::LANE_STAT];
        end
    end

    // Bus answer: one access cycle, error on unmapped address
    // Both answers are combinational from the request, so they stand
    // exactly for the access cycle and drop with penable
    assign prdata  = prdata_reg;
    assign pready  = access_ph;
    assign pslverr = access_ph & ~mapped;

    // Level interrupt from unmasked sticky bits
    // Both operands are registers, so the output does not glitch with the bus
    assign irq = |(irq_status_reg & irq_mask_reg);

endmodule // lane_error_counter_control

// ==== lane_error_counter_sva.sv ====
// Port checker for the lane error counter control block.
// Assumes one pclk domain and the async active-low presetn.
`timescale 1ns/1ps
module lane_error_counter_sva #(
    parameter int NUM_LANES = 8,
    parameter int CNT_W     = 8
) (
    input wire logic                                pclk,
    input wire logic                                presetn,
    input wire lane_error_counter_pkg::apb_req_s    apb_req,
    input wire logic [31:0]                         prdata,
    input wire logic                                pready,
    input wire logic                                pslverr,
    input wire logic [NUM_LANES-1:0][2:0]           lane_err_event,
    input wire logic [NUM_LANES-1:0][2:0]           lane_cnt_clear,
    input wire logic [NUM_LANES-1:0]                lane_enable,
    input wire logic [NUM_LANES-1:0][2:0][CNT_W-1:0] err_count,
    input wire logic [NUM_LANES-1:0][2:0]           terminal_reached,
    input wire logic                                irq
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    // Bus answer, counter behaviour and status read-back
    a_ready_access: assert property (pready == (apb_req.psel && apb_req.penable))
        else $error("ready not tied to the access phase");
    a_sat_hold: assert property (
        err_count[7][2] == 8'hFF && !lane_cnt_clear[7][2] |=> err_count[7][2] == 8'hFF)
        else $error("saturated counter moved");
    a_inc_one: assert property (
        lane_err_event[6][1] && !lane_cnt_clear[6][1] && err_count[6][1] != 8'hFF
        |=> err_count[6][1] == $past(err_count[6][1]) + 8'h01)
        else $error("counter did not step by one");
    a_reach_flag: assert property (err_count[6][2] == 8'hFF |-> terminal_reached[6][2])
        else $error("terminal flag low at terminal count");
    a_flag_sticky: assert property (
        terminal_reached[6][1] && !lane_cnt_clear[6][1] |=> terminal_reached[6][1])
        else $error("terminal flag dropped");
    a_clear_zero: assert property (
        lane_cnt_clear[6][2] && !lane_err_event[6][2]
        |=> err_count[6][2] == 8'h00 && !terminal_reached[6][2])
        else $error("clear left counter or flag");
    a_stat_read: assert property (
        apb_req.psel && apb_req.penable && !apb_req.pwrite && apb_req.paddr == 32'h0000_1240
        |-> prdata[2:0] == $past(terminal_reached[0]) && prdata[31:4] == 28'h000_0000)
        else $error("status read-back wrong");
    a_unmapped_err: assert property (
        apb_req.psel && apb_req.penable && apb_req.paddr == 32'h0000_1300 |-> pslverr)
        else $error("unmapped access not refused");
endmodule // lane_error_counter_sva

bind lane_error_counter_control lane_error_counter_sva #(
    .NUM_LANES(NUM_LANES), .CNT_W(CNT_W)
) lane_error_counter_sva_i (
    .pclk(pclk), .presetn(presetn), .apb_req(apb_req), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .lane_err_event(lane_err_event),
    .lane_cnt_clear(lane_cnt_clear), .lane_enable(lane_enable),
    .err_count(err_count), .terminal_reached(terminal_reached), .irq(irq)
);

// ==== err_source.sv ====
// Far-end model: the lane decoders raising error pulses.
// Assumes pclk from the bench; pulses change just after an edge.
`timescale 1ns/1ps
module err_source (
    input  wire logic       pclk,
    output logic [7:0][2:0] ev
);
    initial ev = '0;
    // Raise one pattern per cycle for n cycles, then go quiet
    task automatic burst(input logic [7:0][2:0] v, input int n);
        repeat (n) begin
            @(posedge pclk);
            ev <= v;
        end
        @(posedge pclk);
        ev <= '0;
    endtask
endmodule // err_source

// ==== tb_lane_error_counter_control.sv ====
// Self-checking bench for the lane error counter control block.
// Assumes the checker is bound in and err_source supplies events.
`timescale 1ns/1ps
module tb_lane_error_counter_control;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    lane_error_counter_pkg::apb_req_s req = '0;
    logic [31:0] prdata, r;
    logic pready, pslverr, irq, e;
    logic [7:0][2:0] ev, clr = '0, tr;
    logic [7:0] ena = '0;
    logic [7:0][2:0][7:0] cnt;
    logic [7:0][2:0] v;
    int errors = 0, checked = 0, cyc = 0;
    lane_error_counter_control lane_error_counter_control_i (
        .pclk(pclk), .presetn(presetn), .apb_req(req), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .lane_err_event(ev), .lane_cnt_clear(clr),
        .lane_enable(ena), .err_count(cnt), .terminal_reached(tr), .irq(irq));
    err_source err_source_i (.pclk(pclk), .ev(ev));
    // Clock and hang guard
    always #2 pclk = ~pclk;
    always @(posedge pclk) begin
        cyc = cyc + 1;
        if (cyc == 5000) begin
            errors = errors + 1;
            give_verdict();
        end
    end
    function automatic logic [31:0] ad(input logic [11:0] i);
        return {18'h0_0000, i, 2'b00};
    endfunction
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checked = checked + 1;
        if (seen !== exp) begin
            errors = errors + 1;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d);
        @(posedge pclk);
        req <= '{1'b1, 1'b0, w, a, d};
        @(posedge pclk);
        req.penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        req <= '0;
    endtask
    // Reset values and plain register access
    task automatic t_regs;
        apb(0, ad(lane_error_counter_pkg::IDX_LANE6_SAT), 0); chk(r, 32'h0000_0007);
        apb(0, ad(lane_error_counter_pkg::IDX_LANE0_STAT), 0); chk(r, 32'h0000_0000);
        apb(1, ad(lane_error_counter_pkg::IDX_LANE6_SAT), 32'hFFFF_FFF5);
        apb(0, ad(lane_error_counter_pkg::IDX_LANE6_SAT), 0); chk(r, 32'h0000_0005);
        apb(0, ad(lane_error_counter_pkg::IDX_LANE7_SAT), 0); chk(r, 32'h0000_0007);
        apb(1, ad(lane_error_counter_pkg::IDX_LANE0_STAT), 32'hFFFF_FFFF);
        apb(0, ad(lane_error_counter_pkg::IDX_LANE0_STAT), 0); chk(r, 32'h0000_0000);
        apb(0, 32'h0000_1300, 0); chk({r[30:0], e}, 32'h0000_0001);
        $display("test regs done");
    endtask
    // Lane 6 holds, wraps, holds; lane 7 holds all; masked status
    task automatic t_sat;
        v = '0;
        v[6] = 3'b111;
        v[7] = 3'b111;
        err_source_i.burst(v, 256);
        @(posedge pclk);
        chk(cnt[6], 24'hFF_00FF);
        chk(cnt[7], 24'hFF_FFFF);
        chk(tr[6], 3'b111);
        apb(0, ad(lane_error_counter_pkg::IDX_IRQ_STATUS), 0); chk(r, 32'h0000_01F8);
        chk(irq, 1'b0);
        $display("test saturate done");
    endtask
    // Lane 0 status, interrupt raise and read-clear, counter clear
    task automatic t_lane0;
        apb(1, ad(lane_error_counter_pkg::IDX_IRQ_MASK), 32'h0000_0004);
        ena[0] <= 1'b1;
        v = '0;
        v[0] = 3'b100;
        err_source_i.burst(v, 255);
        @(posedge pclk);
        chk(irq, 1'b1);
        apb(0, ad(lane_error_counter_pkg::IDX_LANE0_STAT), 0); chk(r, 32'h0000_000C);
        apb(0, ad(lane_error_counter_pkg::IDX_IRQ_STATUS), 0); chk(r, 32'h0000_0004);
        @(posedge pclk);
        chk(irq, 1'b0);
        clr[6][2] <= 1'b1;
        ena[0] <= 1'b0;
        @(posedge pclk);
        clr[6][2] <= 1'b0;
        @(posedge pclk);
        chk({cnt[6][2], tr[6][2]}, 9'h000);
        apb(0, ad(lane_error_counter_pkg::IDX_LANE0_STAT), 0); chk(r, 32'h0000_0004);
        $display("test lane0 done");
    endtask
    task automatic give_verdict;
        $display("checked %0d errors %0d", checked, errors);
        if (errors == 0 && checked > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    // Main sequence
    initial begin
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        t_regs();
        t_sat();
        t_lane0();
        give_verdict();
    end
endmodule // tb_lane_error_counter_control
